/* File: rtl/dbs_top.sv */
// dbs_top: display brightness select with a classic Wishbone register slave
//
// Overview of operation
// - manual brightness ranges 1 to 63, resets to 63.
// - dimmed brightness ranges 0 to 63, 63 brightest, resets to 7.
// - with auto off or no sensor fitted, dimming-assigned input active selects dimmed level, otherwise manual level.
// - auto enabled with sensor fitted takes level from ambient light reading.
// - auto level never above programmable maximum, range 15 to 63, default 63.
// - auto level never below programmable minimum unless minimum exceeds maximum, default 7.
// - auto maximum and minimum visible and writable only while auto is on.
// - each of four inputs has polarity, default low-active.
`timescale 1ns/1ps

module dbs_top
    import dbs_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [ADR_W-1:0]   wb_adr_i,
    input  wire logic [SEL_W-1:0]   wb_sel_i,
    input  wire logic [DAT_W-1:0]   wb_dat_i,
    output logic      [DAT_W-1:0]   wb_dat_o,
    output logic                    wb_ack_o,
    // remote digital input pins
    input  wire logic [NUM_REM-1:0] remote_pin_i,
    // light sensor
    input  wire logic               sensor_fitted_i,
    input  wire logic [LVL_W-1:0]   light_code_i,
    // display drive
    output logic      [LVL_W-1:0]   level_o,
    output logic      [2:0]         level_src_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                 ack_ff;
    logic [DAT_W-1:0]     rdata_ff;
    logic [DAT_W-1:0]     nxt_rdata;
    logic                 wr_commit;
    logic                 lane0_wr;

    logic                 auto_en_ff;
    logic [LVL_W-1:0]     manual_ff;
    logic [LVL_W-1:0]     dimmed_ff;
    logic [LVL_W-1:0]     auto_max_ff;
    logic [LVL_W-1:0]     auto_min_ff;
    logic [NUM_REM-1:0]   polarity_ff;
    logic [NUM_REM-1:0]   dim_assign_ff;

    logic [NUM_REM-1:0]   remote_active;
    logic                 dim_request;
    logic                 auto_live;
    logic [LVL_W-1:0]     light_ff;
    logic [LVL_W-1:0]     light_clamped;
    dbs_src_t             src_ff;
    dbs_src_t             nxt_src;
    logic [LVL_W-1:0]     level_ff;
    logic [LVL_W-1:0]     nxt_level;
    logic [LVL_W-1:0]     wr_code;

    // per-register write strobes
    logic                 wr_ctrl;
    logic                 wr_manual;
    logic                 wr_dimmed;
    logic                 wr_auto_max;
    logic                 wr_auto_min;
    logic                 wr_polarity;
    logic                 wr_dim_assign;

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    // a write lands on the edge where the master samples ack
    assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign lane0_wr  = wr_commit && wb_sel_i[0];
    assign wr_code   = wb_dat_i[LVL_W-1:0];

    assign wb_ack_o  = ack_ff;
    assign wb_dat_o  = rdata_ff;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------

    // registers read as the low bits of a word, rest zero
    always_comb begin
        nxt_rdata = '0;
        unique case (wb_adr_i)
            OFS_CTRL: begin
                nxt_rdata[CTRL_AUTO_BIT] = auto_en_ff;
            end
            OFS_MANUAL: begin
                nxt_rdata[LVL_W-1:0] = manual_ff;
            end
            OFS_DIMMED: begin
                nxt_rdata[LVL_W-1:0] = dimmed_ff;
            end
            OFS_AUTO_MAX: begin
                if (auto_en_ff) begin
                    nxt_rdata[LVL_W-1:0] = auto_max_ff;
                end
            end
            OFS_AUTO_MIN: begin
                if (auto_en_ff) begin
                    nxt_rdata[LVL_W-1:0] = auto_min_ff;
                end
            end
            OFS_POLARITY: begin
                nxt_rdata[NUM_REM-1:0] = polarity_ff;
            end
            OFS_DIM_ASSIGN: begin
                nxt_rdata[NUM_REM-1:0] = dim_assign_ff;
            end
            OFS_STATUS: begin
                nxt_rdata[ST_LEVEL_LSB +: LVL_W]    = level_ff;
                nxt_rdata[ST_ACTIVE_LSB +: NUM_REM] = remote_active;
                nxt_rdata[ST_SRC_LSB +: 3]          = src_ff;
                nxt_rdata[ST_FITTED_BIT]            = sensor_fitted_i;
            end
            default: begin
                nxt_rdata = '0;                         // unmapped reads zero
            end
        endcase
    end

    // read data captured together with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------

    // one strobe per register, every field sits in byte lane 0
    assign wr_ctrl       = lane0_wr && (wb_adr_i == OFS_CTRL);
    assign wr_manual     = lane0_wr && (wb_adr_i == OFS_MANUAL);
    assign wr_dimmed     = lane0_wr && (wb_adr_i == OFS_DIMMED);
    assign wr_polarity   = lane0_wr && (wb_adr_i == OFS_POLARITY);
    assign wr_dim_assign = lane0_wr && (wb_adr_i == OFS_DIM_ASSIGN);

    // limits are hidden while auto is off, so writes to them are dropped
    assign wr_auto_max   = lane0_wr && auto_en_ff && (wb_adr_i == OFS_AUTO_MAX);
    assign wr_auto_min   = lane0_wr && auto_en_ff && (wb_adr_i == OFS_AUTO_MIN);

    // ------------------------------------------------------------------
    // setup registers
    // ------------------------------------------------------------------

    // automatic brightness switch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_en_ff <= AUTO_EN_RST;
        end else if (wr_ctrl) begin
            auto_en_ff <= wb_dat_i[CTRL_AUTO_BIT];
        end
    end

    // manual brightness, out-of-range codes are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            manual_ff <= MANUAL_RST;
        end else if (wr_manual
                     && dbs_in_range(wr_code, MANUAL_LO, LEVEL_HI)) begin
            manual_ff <= wr_code;
        end
    end

    // dimmed brightness, full code range
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dimmed_ff <= DIMMED_RST;
        end else if (wr_dimmed
                     && dbs_in_range(wr_code, DIMMED_LO, LEVEL_HI)) begin
            dimmed_ff <= wr_code;
        end
    end

    // auto upper limit, writable only while auto is on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_max_ff <= AUTO_MAX_RST;
        end else if (wr_auto_max
                     && dbs_in_range(wr_code, AUTO_MAX_LO, LEVEL_HI)) begin
            auto_max_ff <= wr_code;
        end
    end

    // auto lower limit, writable only while auto is on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_min_ff <= AUTO_MIN_RST;
        end else if (wr_auto_min
                     && dbs_in_range(wr_code, AUTO_MIN_LO, LEVEL_HI)) begin
            auto_min_ff <= wr_code;
        end
    end

    // per-input polarity, 0 low-active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            polarity_ff <= POL_RST;
        end else if (wr_polarity) begin
            polarity_ff <= wb_dat_i[NUM_REM-1:0];
        end
    end

    // inputs assigned the dimming function
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dim_assign_ff <= ASSIGN_RST;
        end else if (wr_dim_assign) begin
            dim_assign_ff <= wb_dat_i[NUM_REM-1:0];
        end
    end

    // ------------------------------------------------------------------
    // remote inputs
    // ------------------------------------------------------------------

    // pins to active flags, polarity applied
    dbs_input_sync u_input_sync (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .remote_pin_i (remote_pin_i),
        .polarity_i   (polarity_ff),
        .active_o     (remote_active)
    );

    // any dimming-assigned input active
    assign dim_request = |(remote_active & dim_assign_ff);

    // ------------------------------------------------------------------
    // ambient light path
    // ------------------------------------------------------------------

    // register the sensor code before it meets the limits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            light_ff <= '0;
        end else begin
            light_ff <= light_code_i;
        end
    end

    // hold sensor code between the limits
    dbs_clamp u_clamp (
        .code_i (light_ff),
        .min_i  (auto_min_ff),
        .max_i  (auto_max_ff),
        .code_o (light_clamped)
    );

    assign auto_live = auto_en_ff && sensor_fitted_i;

    // ------------------------------------------------------------------
    // source selection and drive level
    // ------------------------------------------------------------------

    // auto wins, then dimming input, then manual
    always_comb begin
        nxt_src   = DBS_SRC_MANUAL;
        nxt_level = manual_ff;
        if (auto_live) begin
            nxt_src   = DBS_SRC_AUTO;
            nxt_level = light_clamped;
        end else if (dim_request) begin
            nxt_src   = DBS_SRC_DIMMED;
            nxt_level = dimmed_ff;
        end
    end

    // registered drive level and source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_ff   <= DBS_SRC_MANUAL;
            level_ff <= MANUAL_RST;
        end else begin
            src_ff   <= nxt_src;
            level_ff <= nxt_level;
        end
    end

    assign level_o     = level_ff;
    assign level_src_o = src_ff;

endmodule // dbs_top

/* File: shared/dbs_pkg.sv */
// dbs_pkg: constants, register map and types of the display brightness select block
package dbs_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned LVL_W    = 6;   // brightness code width
    localparam int unsigned NUM_REM  = 4;   // remote inputs
    localparam int unsigned ADR_W    = 8;   // decoded byte address bits
    localparam int unsigned DAT_W    = 32;  // bus data width
    localparam int unsigned SEL_W    = 4;   // byte enables

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_MANUAL     = 8'h04;
    localparam logic [7:0] OFS_DIMMED     = 8'h08;
    localparam logic [7:0] OFS_AUTO_MAX   = 8'h0C;
    localparam logic [7:0] OFS_AUTO_MIN   = 8'h10;
    localparam logic [7:0] OFS_POLARITY   = 8'h14;
    localparam logic [7:0] OFS_DIM_ASSIGN = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_AUTO_BIT   = 0;   // auto_brightness_enable
    localparam int unsigned ST_LEVEL_LSB    = 0;   // status: current level
    localparam int unsigned ST_ACTIVE_LSB   = 8;   // status: active inputs
    localparam int unsigned ST_SRC_LSB      = 12;  // status: source, one-hot
    localparam int unsigned ST_FITTED_BIT   = 15;  // status: sensor fitted

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [LVL_W-1:0] MANUAL_RST   = 6'h3F;  // 63
    localparam logic [LVL_W-1:0] MANUAL_LO    = 6'h01;  // 1
    localparam logic [LVL_W-1:0] DIMMED_RST   = 6'h07;  // 7
    localparam logic [LVL_W-1:0] DIMMED_LO    = 6'h00;  // 0
    localparam logic [LVL_W-1:0] AUTO_MAX_RST = 6'h3F;  // 63
    localparam logic [LVL_W-1:0] AUTO_MAX_LO  = 6'h0F;  // 15
    localparam logic [LVL_W-1:0] AUTO_MIN_RST = 6'h07;  // 7
    localparam logic [LVL_W-1:0] AUTO_MIN_LO  = 6'h01;  // 1
    localparam logic [LVL_W-1:0] LEVEL_HI     = 6'h3F;  // 63, top of every range
    localparam logic             AUTO_EN_RST  = 1'b1;
    localparam logic [NUM_REM-1:0] POL_RST    = 4'h0;   // all low-active
    localparam logic [NUM_REM-1:0] ASSIGN_RST = 4'h0;   // no dimming input

    // ------------------------------------------------------------------
    // drive source
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DBS_SRC_MANUAL = 3'b001,
        DBS_SRC_DIMMED = 3'b010,
        DBS_SRC_AUTO   = 3'b100
    } dbs_src_t;

    // true when lo <= val <= hi
    function automatic logic dbs_in_range(input logic [LVL_W-1:0] val,
                                          input logic [LVL_W-1:0] lo,
                                          input logic [LVL_W-1:0] hi);
        return (val >= lo) && (val <= hi);
    endfunction

endpackage

/* File: rtl/dbs_input_sync.sv */
// dbs_input_sync: three-stage synchroniser and polarity for the remote inputs
`timescale 1ns/1ps

module dbs_input_sync
    import dbs_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [NUM_REM-1:0] remote_pin_i,
    input  wire logic [NUM_REM-1:0] polarity_i,
    output logic      [NUM_REM-1:0] active_o
);

    logic [NUM_REM-1:0] meta_ff;
    logic [NUM_REM-1:0] sync2_ff;
    logic [NUM_REM-1:0] sync3_ff;
    logic [NUM_REM-1:0] level_ff;

    // ------------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff  <= {NUM_REM{1'b1}};   // idle level of a pulled-up input
            sync2_ff <= {NUM_REM{1'b1}};
            sync3_ff <= {NUM_REM{1'b1}};
        end else begin
            meta_ff  <= remote_pin_i;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // accept a level once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_ff <= {NUM_REM{1'b1}};
        end else begin
            for (int i = 0; i < NUM_REM; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    level_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    // polarity 0: low level active, 1: high level active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_o <= '0;
        end else begin
            active_o <= ~(level_ff ^ polarity_i);
        end
    end

endmodule // dbs_input_sync

/* File: rtl/dbs_clamp.sv */
// dbs_clamp: holds a sensor-derived code between a lower and an upper limit
`timescale 1ns/1ps

module dbs_clamp
    import dbs_pkg::*;
(
    input  wire logic [LVL_W-1:0] code_i,
    input  wire logic [LVL_W-1:0] min_i,
    input  wire logic [LVL_W-1:0] max_i,
    output logic      [LVL_W-1:0] code_o
);

    // lower limit first, upper limit last so it wins if min exceeds max
    always_comb begin
        code_o = code_i;
        if (code_i < min_i) begin
            code_o = min_i;
        end
        if (code_o > max_i) begin
            code_o = max_i;
        end
    end

endmodule // dbs_clamp

/* File: verif/dbs_top_sva.sv */
// dbs_top_sva: bus and level-select assertions for dbs_top
`timescale 1ns/1ps

module dbs_top_sva
    import dbs_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [ADR_W-1:0]   wb_adr_i,
    input wire logic [SEL_W-1:0]   wb_sel_i,
    input wire logic [DAT_W-1:0]   wb_dat_i,
    input wire logic [DAT_W-1:0]   wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic [NUM_REM-1:0] remote_pin_i,
    input wire logic               sensor_fitted_i,
    input wire logic [LVL_W-1:0]   light_code_i,
    input wire logic [LVL_W-1:0]   level_o,
    input wire logic [2:0]         level_src_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // bus request shapes
    // ----------------------------------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read_req;
        s_req ##0 !wb_we_i;
    endsequence

    a_ack_next_cycle: assert property (s_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_read_zero: assert property (s_read_req ##0
        (wb_adr_i > OFS_STATUS || wb_adr_i[1:0] != 2'b00) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_status_mirror: assert property (s_read_req ##0 (wb_adr_i == OFS_STATUS) |=>
        wb_dat_o[5:0] == $past(level_o) && wb_dat_o[14:12] == $past(level_src_o)
        && wb_dat_o[15] == $past(sensor_fitted_i))
        else $error("status read does not mirror outputs");

    // ----------------------------------------------------------------
    // level source and range
    // ----------------------------------------------------------------
    a_reset_level: assert property ($fell(rst_i) |->
        level_o == MANUAL_RST && level_src_o == DBS_SRC_MANUAL)
        else $error("level after reset not manual default");
    a_src_one_hot: assert property ($onehot(level_src_o))
        else $error("level source not one-hot");
    a_auto_needs_sensor: assert property (level_src_o == DBS_SRC_AUTO |->
        $past(sensor_fitted_i))
        else $error("auto source without sensor");
    a_auto_floor: assert property (level_src_o == DBS_SRC_AUTO |->
        level_o >= AUTO_MIN_LO)
        else $error("auto level below floor");
    a_manual_floor: assert property (level_src_o == DBS_SRC_MANUAL |->
        level_o >= MANUAL_LO)
        else $error("manual level below one");

    c_dimmed: cover property (level_src_o == DBS_SRC_DIMMED);
endmodule // dbs_top_sva

bind dbs_top dbs_top_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .remote_pin_i(remote_pin_i),
    .sensor_fitted_i(sensor_fitted_i), .light_code_i(light_code_i),
    .level_o(level_o), .level_src_o(level_src_o)
);

/* File: verif/display_brightness_select_tb.sv */
// display_brightness_select_tb: register-level tests of dbs_top
`timescale 1ns/1ps

module display_brightness_select_tb
    import dbs_pkg::*;
;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               wb_cyc_i = 1'b0;
    logic               wb_stb_i = 1'b0;
    logic               wb_we_i = 1'b0;
    logic [ADR_W-1:0]   wb_adr_i = 8'h00;
    logic [SEL_W-1:0]   wb_sel_i = 4'h0;
    logic [DAT_W-1:0]   wb_dat_i = 32'h0;
    logic [DAT_W-1:0]   wb_dat_o;
    logic               wb_ack_o;
    logic [NUM_REM-1:0] remote_pin_i = 4'hF;  // idle high, inactive
    logic               sensor_fitted_i = 1'b0;
    logic [LVL_W-1:0]   light_code_i = 6'h00;
    logic [LVL_W-1:0]   level_o;
    logic [2:0]         level_src_o;
    int                 mismatches = 0;
    int                 num_checks = 0;
    int                 cycles = 0;
    logic [DAT_W-1:0]   scratch_rd;
    logic [7:0]  def_adr [9] = '{OFS_CTRL, OFS_MANUAL, OFS_DIMMED, OFS_AUTO_MAX,
        OFS_AUTO_MIN, OFS_POLARITY, OFS_DIM_ASSIGN, OFS_STATUS, 8'h20};
    logic [31:0] def_val [9] = '{32'h1, 32'h3F, 32'h7, 32'h3F, 32'h7, 32'h0, 32'h0,
        32'h103F, 32'h0};

    always #12.5 clk_i = ~clk_i;

    dbs_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .remote_pin_i(remote_pin_i),
        .sensor_fitted_i(sensor_fitted_i), .light_code_i(light_code_i),
        .level_o(level_o), .level_src_o(level_src_o)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // classic cycle: hold until ack is sampled, then release
    task automatic wb_xfer(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                           input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        // ack and read data are taken at the edge where ack is sampled high
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wdat);
        logic [31:0] d;
        wb_xfer(1'b1, 4'hF, adr, wdat, d);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, 4'hF, adr, 32'h0, d);
        check("read data", d, exp);
    endtask

    // let outputs settle, then compare level and source
    task automatic lvl(input int n, input logic [5:0] exp, input logic [2:0] src);
        repeat (n) @(posedge clk_i);
        #1;
        check("level_o", 32'(level_o), 32'(exp));
        check("level_src_o", 32'(level_src_o), 32'(src));
    endtask

    task automatic drive(input logic [3:0] pins, input logic fit, input logic [5:0] code);
        @(posedge clk_i);
        remote_pin_i    <= pins;
        sensor_fitted_i <= fit;
        light_code_i    <= code;
    endtask

    // cycle ceiling against hangs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        lvl(1, 6'h3F, DBS_SRC_MANUAL);
        for (int k = 0; k < 9; k++) begin
            rd(def_adr[k], def_val[k]);
        end
        // manual range edges
        wr(OFS_MANUAL, 32'h0);
        rd(OFS_MANUAL, 32'h3F);
        wr(OFS_MANUAL, 32'h1);
        lvl(2, 6'h01, DBS_SRC_MANUAL);
        wr(OFS_MANUAL, 32'h3F);
        // write without byte lane 0 is dropped
        wb_xfer(1'b1, 4'hE, OFS_MANUAL, 32'h5, scratch_rd);
        rd(OFS_MANUAL, 32'h3F);
        // each input in turn as dimming input, low-active
        for (int i = 0; i < 4; i++) begin
            wr(OFS_DIM_ASSIGN, 32'h1 << i);
            drive(4'hF ^ (4'h1 << i), 1'b0, 6'h00);
            lvl(7, 6'h07, DBS_SRC_DIMMED);
            rd(OFS_STATUS, 32'h2007 | (32'h100 << i));
            drive(4'hF ^ (4'h1 << ((i + 1) % 4)), 1'b0, 6'h00);
            lvl(7, 6'h3F, DBS_SRC_MANUAL);
        end
        // high-active polarity and lowest dimmed code
        wr(OFS_DIM_ASSIGN, 32'h1);
        wr(OFS_POLARITY, 32'h1);
        drive(4'hF, 1'b0, 6'h00);
        lvl(7, 6'h07, DBS_SRC_DIMMED);
        wr(OFS_DIMMED, 32'h0);
        lvl(2, 6'h00, DBS_SRC_DIMMED);
        drive(4'hE, 1'b0, 6'h00);
        lvl(7, 6'h3F, DBS_SRC_MANUAL);
        wr(OFS_POLARITY, 32'h0);
        wr(OFS_DIM_ASSIGN, 32'h0);
        // sensor-derived level and its limits
        drive(4'hF, 1'b1, 6'h20);
        lvl(3, 6'h20, DBS_SRC_AUTO);
        drive(4'hF, 1'b1, 6'h02);
        lvl(3, 6'h07, DBS_SRC_AUTO);
        wr(OFS_AUTO_MAX, 32'h0E);
        rd(OFS_AUTO_MAX, 32'h3F);
        wr(OFS_AUTO_MAX, 32'h0F);
        drive(4'hF, 1'b1, 6'h3F);
        lvl(3, 6'h0F, DBS_SRC_AUTO);
        wr(OFS_AUTO_MIN, 32'h0A);
        drive(4'hF, 1'b1, 6'h00);
        lvl(3, 6'h0A, DBS_SRC_AUTO);
        // limits hidden while auto is off
        wr(OFS_CTRL, 32'h0);
        rd(OFS_AUTO_MAX, 32'h0);
        rd(OFS_AUTO_MIN, 32'h0);
        wr(OFS_AUTO_MAX, 32'h20);
        lvl(1, 6'h3F, DBS_SRC_MANUAL);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_AUTO_MAX, 32'h0F);
        lvl(1, 6'h0A, DBS_SRC_AUTO);
        drive(4'hF, 1'b0, 6'h20);
        lvl(3, 6'h3F, DBS_SRC_MANUAL);
        test_done();
    end
endmodule // display_brightness_select_tb
